// file: rtl/udc_pkg.sv
// Constants and types for the USB device core control block.
// Summary of operation
// R1 - System resets disable and reset the controller
// R2 - Bus end-of-reset resets state, stays enabled
// R3 - Reset state: enable clear, frozen, suspended
// R4 - Access bits and speed writable during reset
// R5 - Enable enters device state; clear resets
// R6 - Separate general and endpoint interrupt outputs
// R7 - Wake flag set asynchronously by line changes
// R8 - Other interrupts only while clock runs
// R9 - Eight enabled sources per endpoint interrupt
// R10 - Any USB interrupt wakes idle CPU
// R11 - Core registers accessible while clock frozen; endpoint config writes are ignored while frozen
// R12 - Frozen clock allows only the wake interrupt
// R13 - 176 bytes, endpoints up to 64 bytes
// R14 - Firmware reserves endpoints in increasing order
// R15 - Reserve inserts region, next slides up
// R16 - Deactivating keeps reserve, size and banks; a config write reloads them from the written byte
// R17 - Freeing slides next region down only
// R18 - Endpoint zero data kept by higher changes
// R19 - Same-parameter reactivation does not slide
// R20 - Config valid set even on overlap
// R21 - Suspend sets flag and idles pads
// R22 - Non-idle event sets wake, pads active
// R23 - Disconnect bit idles pads; clear restores
// R24 - Enable drives controller and line buffers
// R25 - Frozen clock holds flags, resume detected
// R26 - Disconnect set after reset; pull-up after clear
// R27 - Wake flag synchronised before read or clear
package udc_pkg;

  // ==========================================================
  // Register byte addresses
  localparam logic [7:0] ADDR_GENERAL_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_DEVICE_CONTROL  = 8'h04;
  localparam logic [7:0] ADDR_DEVICE_INT      = 8'h08;
  localparam logic [7:0] ADDR_DEVICE_INT_EN   = 8'h0C;
  localparam logic [7:0] ADDR_MEM_ADDRESS     = 8'h10;
  localparam logic [7:0] ADDR_EP_SELECT       = 8'h14;
  localparam logic [7:0] ADDR_EP_CONFIG       = 8'h18;
  localparam logic [7:0] ADDR_EP_INT          = 8'h1C;
  localparam logic [7:0] ADDR_EP_INT_EN       = 8'h20;
  localparam logic [7:0] ADDR_EP_BASE         = 8'h24;

  // ==========================================================
  // General control fields
  localparam int GC_MACRO_ENABLE = 7;
  localparam int GC_CLOCK_FREEZE = 5;
  localparam int GC_SPEED_LSB    = 0;
  localparam int SPEED_W         = 2;
  // Device control fields
  localparam int DC_DETACH       = 0;
  // Device interrupt fields
  localparam int DI_SUSPEND      = 0;
  localparam int DI_END_OF_RESET = 3;
  localparam int DI_WAKE         = 4;
  localparam int DI_W            = 5;
  // Memory address register fields
  localparam int MA_ENABLE       = 16;
  localparam int MA_ADDR_W       = 11;
  // Endpoint configuration fields
  localparam int EC_ACTIVATE     = 0;
  localparam int EC_RESERVE      = 1;
  localparam int EC_BANKS        = 2;
  localparam int EC_SIZE_LSB     = 4;
  localparam int EC_CFG_VALID    = 8;
  localparam int SIZE_W          = 3;

  // ==========================================================
  // Endpoint memory layout
  localparam int NUM_EP          = 5;
  localparam int EP_IDX_W        = 3;
  localparam int MEM_BYTES       = 176;
  localparam int MEM_PTR_W       = 9;
  localparam int EP_SRC_W        = 8;
  localparam int MAX_EP_BYTES    = 64;
  localparam int FIRST_DUAL_EP   = 3;

  // Reset values
  localparam logic [7:0] GC_RESET = 8'h20;
  localparam logic       DETACH_RESET = 1'b1;

  // Controller operating state.
  typedef enum logic [2:0] {
    UDC_RESET   = 3'b001,
    UDC_DEVICE  = 3'b010,
    UDC_FROZEN  = 3'b100
  } udc_mode_t;

endpackage

// file: rtl/udc_core_ctrl.sv
// General control, interrupts, pads and endpoint memory layout.
//
// Decided for this implementation: the APB register port and the address map.
`timescale 1ns/10ps
module udc_core_ctrl
  import udc_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        rst_i,
  // APB slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // System resets other than the bus
  input  wire logic        sys_reset_req_i,
  // Bus events from the serial engine
  input  wire logic        bus_end_of_reset_i,
  input  wire logic        bus_suspend_i,
  input  wire logic        bus_non_idle_i,
  input  wire logic        dplus_i,
  input  wire logic        dminus_i,
  // Endpoint event sources
  input  wire logic [39:0] ep_events_i,
  // Controls to the pads and engine
  output logic             line_buffers_en_o,
  output logic             pads_idle_o,
  output logic             pullup_en_o,
  output logic             ctrl_clk_en_o,
  output logic             ctrl_soft_reset_o,
  output logic             memory_direct_access_enable_o,
  output logic [10:0]      memory_direct_access_address_o,
  output logic [1:0]       speed_config_bits_o,
  output logic [44:0]      ep_region_o,
  // Interrupt vectors and CPU wake
  output logic             general_irq_o,
  output logic             endpoint_irq_o,
  output logic             cpu_wake_o
);

  // ==========================================================
  // State record
  typedef struct packed {
    logic                         macro_enable;
    logic                         controller_clock_freeze;
    logic [SPEED_W-1:0]           speed;
    logic                         detach;
    logic [DI_W-1:0]              dev_int;
    logic [DI_W-1:0]              dev_int_en;
    logic                         mem_acc_en;
    logic [MA_ADDR_W-1:0]         mem_addr;
    logic [EP_IDX_W-1:0]          ep_sel;
    logic [NUM_EP-1:0]            ep_act;
    logic [NUM_EP-1:0]            ep_rsv;
    logic [NUM_EP-1:0]            ep_bank2;
    logic [NUM_EP*SIZE_W-1:0]     ep_size;
    logic [NUM_EP-1:0]            ep_cfg_ok;
    logic [NUM_EP*MEM_PTR_W-1:0]  ep_base;
    logic [NUM_EP*EP_SRC_W-1:0]   ep_int;
    logic [NUM_EP*EP_SRC_W-1:0]   ep_int_en;
    logic                         dp_seen;
    logic                         dm_seen;
    logic                         dp_s1;
    logic                         dp_s2;
    logic                         dm_s1;
    logic                         dm_s2;
    logic [31:0]                  rdata;
    udc_mode_t                    mode;
  } udc_state_t;

  udc_state_t s_q;
  udc_state_t s_d;

  // Region length of one endpoint from size code and bank count.
  function automatic logic [MEM_PTR_W-1:0] ep_len(
    input logic [SIZE_W-1:0] size, input logic bank2, input logic rsv);
    logic [MEM_PTR_W-1:0] len;
    len = MEM_PTR_W'(8) << size;
    if (size > SIZE_W'(3)) len = MEM_PTR_W'(MAX_EP_BYTES);
    if (bank2) len = len << 1;
    return rsv ? len : '0;
  endfunction

  // ==========================================================
  // Wake capture on line edges with no clock needed. The flag
  // toggles on any line change, so it works while the core
  // clock is frozen or the oscillator is stopped.
  logic line_toggle_q;
  always_ff @(posedge dplus_i or negedge dplus_i or posedge rst_i) begin
    if (rst_i) line_toggle_q <= 1'b0;
    else       line_toggle_q <= ~line_toggle_q; // R7
  end
  logic line_toggle_m_q;
  always_ff @(posedge dminus_i or negedge dminus_i or posedge rst_i) begin
    if (rst_i) line_toggle_m_q <= 1'b0;
    else       line_toggle_m_q <= ~line_toggle_m_q; // R7
  end

  // APB access strobes; the slave always answers at once.
  logic acc;
  logic wr;
  logic rd_ok;
  assign acc = psel_i && penable_i;
  assign wr  = acc && pwrite_i;

  // ==========================================================
  // Next state.
  always_comb begin
    logic                 frozen;
    logic                 running;
    logic                 wake_evt;
    logic [MEM_PTR_W-1:0] nb;
    logic [EP_IDX_W-1:0]  k;
    logic [7:0]           ep_cfg_w;
    s_d      = s_q;
    frozen   = 1'b0;
    running  = 1'b0;
    wake_evt = 1'b0;
    nb       = '0;
    k        = s_q.ep_sel;
    ep_cfg_w = pwdata_i[7:0];
    rd_ok    = 1'b1;

    // Line state synchronisers.
    s_d.dp_s1      = line_toggle_q;
    s_d.dp_s2      = s_q.dp_s1;
    s_d.dm_s1      = line_toggle_m_q;
    s_d.dm_s2      = s_q.dm_s1;
    // Each line is watched on its own: a K state flips both
    // lines at once, which an XOR of the two would miss.
    wake_evt = (s_q.dp_s2 != s_q.dp_seen) ||
               (s_q.dm_s2 != s_q.dm_seen) || bus_non_idle_i; // R27
    s_d.dp_seen = s_q.dp_s2;
    s_d.dm_seen = s_q.dm_s2;

    frozen  = s_q.controller_clock_freeze;
    running = s_q.macro_enable && !frozen;

    // Synchronous sources only while clock runs; flags hold.
    if (running) begin
      if (bus_suspend_i)      s_d.dev_int[DI_SUSPEND] = 1'b1; // R21 R8
      if (bus_end_of_reset_i) s_d.dev_int[DI_END_OF_RESET] = 1'b1;
      for (int e = 0; e < NUM_EP; e++) begin
        s_d.ep_int[e*EP_SRC_W +: EP_SRC_W] =
          s_q.ep_int[e*EP_SRC_W +: EP_SRC_W] |
          ep_events_i[e*EP_SRC_W +: EP_SRC_W]; // R9 R25
      end
    end

    // ========================================================
    // Register writes. Clears are write-zero; device flags lose to sets, endpoint event sets lose to clears.
    if (wr) begin
      unique case (paddr_i)
        ADDR_GENERAL_CONTROL: begin
          s_d.macro_enable = pwdata_i[GC_MACRO_ENABLE]; // R5 R24
          s_d.controller_clock_freeze = pwdata_i[GC_CLOCK_FREEZE];
          s_d.speed = pwdata_i[GC_SPEED_LSB +: SPEED_W]; // R4
        end
        ADDR_DEVICE_CONTROL: s_d.detach = pwdata_i[DC_DETACH]; // R23 R11
        ADDR_DEVICE_INT:
          s_d.dev_int = s_q.dev_int & pwdata_i[DI_W-1:0]; // R11
        ADDR_DEVICE_INT_EN: s_d.dev_int_en = pwdata_i[DI_W-1:0];
        ADDR_MEM_ADDRESS: begin
          s_d.mem_acc_en = pwdata_i[MA_ENABLE]; // R4
          s_d.mem_addr   = pwdata_i[MA_ADDR_W-1:0];
        end
        ADDR_EP_SELECT: s_d.ep_sel = pwdata_i[EP_IDX_W-1:0];
        ADDR_EP_CONFIG: if (!frozen && k < EP_IDX_W'(NUM_EP)) begin
          // Deactivation reloads reserve, size and banks from the written byte.
          s_d.ep_act[k]   = ep_cfg_w[EC_ACTIVATE]; // R16
          s_d.ep_rsv[k]   = ep_cfg_w[EC_RESERVE];
          s_d.ep_bank2[k] = ep_cfg_w[EC_BANKS] &&
                            (k >= EP_IDX_W'(FIRST_DUAL_EP)); // R13
          s_d.ep_size[k*SIZE_W +: SIZE_W] =
            ep_cfg_w[EC_SIZE_LSB +: SIZE_W];
          // The new region starts right after the previous one,
          // and only the next region is relocated behind it.
          if (k != '0) begin
            nb = s_q.ep_base[(k-1)*MEM_PTR_W +: MEM_PTR_W] +
                 ep_len(s_q.ep_size[(k-1)*SIZE_W +: SIZE_W],
                        s_q.ep_bank2[k-1], s_q.ep_rsv[k-1]);
            s_d.ep_base[k*MEM_PTR_W +: MEM_PTR_W] = nb; // R15 R18
          end else begin
            nb = '0;
          end
          if (k < EP_IDX_W'(NUM_EP-1)) begin
            // Same parameters give the same end point, so the
            // next region lands where it was.
            s_d.ep_base[(k+1)*MEM_PTR_W +: MEM_PTR_W] = nb +
              ep_len(s_d.ep_size[k*SIZE_W +: SIZE_W],
                     s_d.ep_bank2[k], s_d.ep_rsv[k]); // R15 R17 R19
          end
          // Valid is set whether or not regions overlap.
          s_d.ep_cfg_ok[k] = ep_cfg_w[EC_RESERVE]; // R20
        end
        ADDR_EP_INT: if (k < EP_IDX_W'(NUM_EP))
          s_d.ep_int[k*EP_SRC_W +: EP_SRC_W] =
            s_q.ep_int[k*EP_SRC_W +: EP_SRC_W] & pwdata_i[7:0];
        ADDR_EP_INT_EN: if (k < EP_IDX_W'(NUM_EP))
          s_d.ep_int_en[k*EP_SRC_W +: EP_SRC_W] = pwdata_i[7:0];
        default: ;
      endcase
    end

    // Device interrupt sets win over clears in the same cycle.
    if (running && bus_suspend_i) s_d.dev_int[DI_SUSPEND] = 1'b1;
    if (running && bus_end_of_reset_i)
      s_d.dev_int[DI_END_OF_RESET] = 1'b1;
    if (wake_evt) begin
      s_d.dev_int[DI_WAKE]    = 1'b1; // R7 R12 R22
      s_d.dev_int[DI_SUSPEND] = 1'b0; // R22
    end

    // Bus end-of-reset resets device state but keeps enable.
    if (running && bus_end_of_reset_i) begin
      s_d.ep_act    = '0; // R2
      s_d.ep_int    = '0;
      s_d.ep_int_en = '0;
    end

    // Controller mode follows enable and freeze.
    if (!s_d.macro_enable)                s_d.mode = UDC_RESET;  // R5
    else if (s_d.controller_clock_freeze) s_d.mode = UDC_FROZEN;
    else                                  s_d.mode = UDC_DEVICE;

    // Clearing enable resets device state; memory config and
    // access fields survive, and the clock freezes.
    if (!s_d.macro_enable) begin
      s_d.controller_clock_freeze = 1'b1; // R3
      s_d.detach    = DETACH_RESET;
      s_d.dev_int   = '0;
      s_d.dev_int_en = '0;
      s_d.ep_act    = '0;
      s_d.ep_int    = '0;
      s_d.ep_int_en = '0;
    end

    // Read data.
    s_d.rdata = '0;
    unique case (paddr_i)
      ADDR_GENERAL_CONTROL: begin
        s_d.rdata[GC_MACRO_ENABLE] = s_q.macro_enable; // R3
        s_d.rdata[GC_CLOCK_FREEZE] = s_q.controller_clock_freeze;
        s_d.rdata[GC_SPEED_LSB +: SPEED_W] = s_q.speed;
      end
      ADDR_DEVICE_CONTROL: s_d.rdata[DC_DETACH] = s_q.detach;
      ADDR_DEVICE_INT:     s_d.rdata[DI_W-1:0] = s_q.dev_int;
      ADDR_DEVICE_INT_EN:  s_d.rdata[DI_W-1:0] = s_q.dev_int_en;
      ADDR_MEM_ADDRESS: begin
        s_d.rdata[MA_ENABLE] = s_q.mem_acc_en;
        s_d.rdata[MA_ADDR_W-1:0] = s_q.mem_addr;
      end
      ADDR_EP_SELECT: s_d.rdata[EP_IDX_W-1:0] = s_q.ep_sel;
      ADDR_EP_CONFIG: if (k < EP_IDX_W'(NUM_EP)) begin
        s_d.rdata[EC_ACTIVATE] = s_q.ep_act[k];
        s_d.rdata[EC_RESERVE]  = s_q.ep_rsv[k];
        s_d.rdata[EC_BANKS]    = s_q.ep_bank2[k];
        s_d.rdata[EC_SIZE_LSB +: SIZE_W] =
          s_q.ep_size[k*SIZE_W +: SIZE_W];
        s_d.rdata[EC_CFG_VALID] = s_q.ep_cfg_ok[k];
      end
      ADDR_EP_INT: if (k < EP_IDX_W'(NUM_EP))
        s_d.rdata[7:0] = s_q.ep_int[k*EP_SRC_W +: EP_SRC_W];
      ADDR_EP_INT_EN: if (k < EP_IDX_W'(NUM_EP))
        s_d.rdata[7:0] = s_q.ep_int_en[k*EP_SRC_W +: EP_SRC_W];
      ADDR_EP_BASE: if (k < EP_IDX_W'(NUM_EP))
        s_d.rdata[MEM_PTR_W-1:0] = s_q.ep_base[k*MEM_PTR_W +: MEM_PTR_W];
      default: rd_ok = 1'b0;
    endcase
  end

  // ==========================================================
  // State register; system reset disables and resets all.
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      s_q <= '0; // R1
      s_q.controller_clock_freeze <= 1'b1; // R3
      s_q.detach <= DETACH_RESET; // R26
      s_q.mode   <= UDC_RESET;
    end else if (sys_reset_req_i) begin
      s_q <= '0; // R1
      s_q.controller_clock_freeze <= 1'b1;
      s_q.detach <= DETACH_RESET;
      s_q.mode   <= UDC_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // Outputs. The bus answers in the access cycle; an unmapped
  // address errors, a frozen core still answers for all.
  assign pready_o  = 1'b1;
  assign pslverr_o = acc && !rd_ok;
  assign prdata_o  = s_d.rdata;
  assign line_buffers_en_o = s_q.macro_enable; // R24
  // Pads idle in suspend or when detached.
  assign pads_idle_o = s_q.dev_int[DI_SUSPEND] || s_q.detach; // R21 R23
  assign pullup_en_o = s_q.macro_enable && !s_q.detach; // R26
  assign ctrl_clk_en_o = s_q.mode == UDC_DEVICE; // R3
  assign ctrl_soft_reset_o = s_q.mode == UDC_RESET;
  assign memory_direct_access_enable_o  = s_q.mem_acc_en;
  assign memory_direct_access_address_o = s_q.mem_addr;
  assign speed_config_bits_o = s_q.speed;
  assign ep_region_o = s_q.ep_base;
  // Two vectors; endpoint vector from enabled sources.
  assign general_irq_o = |(s_q.dev_int & s_q.dev_int_en); // R6
  assign endpoint_irq_o = |(s_q.ep_int & s_q.ep_int_en); // R9
  assign cpu_wake_o = general_irq_o || endpoint_irq_o; // R10

  // ==========================================================
  // Checks.
  sequence s_cleared;
    wr && paddr_i == ADDR_GENERAL_CONTROL && !pwdata_i[GC_MACRO_ENABLE];
  endsequence
  property p_disable;
    @(posedge clk_sys_i) disable iff (rst_i)
      s_cleared |=> ctrl_soft_reset_o && !line_buffers_en_o;
  endproperty
  a_disable: assert property (p_disable) // R5
    else $error("Clearing enable did not reset controller.");
  property p_detach_pads;
    @(posedge clk_sys_i) disable iff (rst_i)
      s_q.detach |-> pads_idle_o && !pullup_en_o;
  endproperty
  a_detach_pads: assert property (p_detach_pads) // R23
    else $error("Detached pads not idle.");
  property p_frozen_hold;
    @(posedge clk_sys_i) disable iff (rst_i)
      (ctrl_clk_en_o == 1'b0 && !wr && !sys_reset_req_i &&
       s_q.macro_enable) |=> s_q.ep_int == $past(s_q.ep_int);
  endproperty
  a_frozen_hold: assert property (p_frozen_hold) // R25
    else $error("Endpoint flags changed while frozen.");
  property p_eor_enabled;
    @(posedge clk_sys_i) disable iff (rst_i)
      (ctrl_clk_en_o && bus_end_of_reset_i && !wr && !sys_reset_req_i)
        |=> s_q.macro_enable && s_q.ep_act == '0;
  endproperty
  a_eor_enabled: assert property (p_eor_enabled) // R2
    else $error("End of reset lost enable.");
  property p_ep_irq;
    @(posedge clk_sys_i) disable iff (rst_i)
      |(s_q.ep_int & s_q.ep_int_en) |-> endpoint_irq_o && cpu_wake_o;
  endproperty
  a_ep_irq: assert property (p_ep_irq) // R9
    else $error("Endpoint vector not raised.");
  property p_reset_state;
    @(posedge clk_sys_i) disable iff (rst_i)
      ctrl_soft_reset_o |-> s_q.controller_clock_freeze && !ctrl_clk_en_o;
  endproperty
  a_reset_state: assert property (p_reset_state) // R3
    else $error("Reset state not frozen.");
  property p_suspend_idle;
    @(posedge clk_sys_i) disable iff (rst_i)
      (ctrl_clk_en_o && bus_suspend_i && !sys_reset_req_i &&
       s_d.macro_enable) |=> pads_idle_o;
  endproperty
  a_suspend_idle: assert property (p_suspend_idle) // R21
    else $error("Suspend did not idle pads.");
  property p_ep0_fixed;
    @(posedge clk_sys_i) disable iff (rst_i)
      ##1 s_q.ep_base[MEM_PTR_W-1:0] == '0;
  endproperty
  a_ep0_fixed: assert property (p_ep0_fixed) // R18
    else $error("Endpoint zero region moved.");

endmodule

// file: tb/udc_usb_host_model.sv
// USB host model that drives bus events and data line levels.
`timescale 1ns/10ps
module udc_usb_host_model (
  // Clock
  input  wire logic clk_sys_i,
  // Bus side towards the controller
  output logic      bus_end_of_reset_o,
  output logic      bus_suspend_o,
  output logic      bus_non_idle_o,
  output logic      dplus_o,
  output logic      dminus_o
);
  // ==========================================================
  // Lines start in the full-speed idle state, no event pending.
  initial begin
    bus_end_of_reset_o = 1'b0;
    bus_suspend_o      = 1'b0;
    bus_non_idle_o     = 1'b0;
    dplus_o            = 1'b1;
    dminus_o           = 1'b0;
  end

  // One-cycle bus event: 0 suspend, 1 non-idle, 2 end of reset.
  task automatic pulse(input int kind);
    @(posedge clk_sys_i);
    bus_suspend_o      <= (kind == 0);
    bus_non_idle_o     <= (kind == 1);
    bus_end_of_reset_o <= (kind == 2);
    @(posedge clk_sys_i);
    bus_suspend_o      <= 1'b0;
    bus_non_idle_o     <= 1'b0;
    bus_end_of_reset_o <= 1'b0;
  endtask

  // Resume signalling puts a short K state on the lines.
  task automatic resume();
    @(posedge clk_sys_i);
    dplus_o  <= 1'b0;
    dminus_o <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    dplus_o  <= 1'b1;
    dminus_o <= 1'b0;
  endtask
endmodule

// file: tb/udc_core_ctrl_tb_top.sv
// Self-checking bench for the USB device core control block.
`timescale 1ns/10ps
module udc_core_ctrl_tb_top;
  import udc_pkg::*;
  logic clk_sys_i, rst_i, psel_i, penable_i, pwrite_i, sys_reset_req_i;
  logic [7:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o, rdata;
  logic pready_o, pslverr_o, last_err, bus_end_of_reset, susp, nidle, dp, dm;
  logic [39:0] ep_events_i;
  logic lbuf, idle, pull, clken, srst, gen_irq, ep_irq, wake;
  logic [10:0] maddr;
  logic [1:0] spd;
  logic [44:0] region;
  logic maen;
  int mismatches, checks_done;

  // ==========================================================
  // Clock, reset and time-zero input values.
  always #5 clk_sys_i = ~clk_sys_i;
  initial begin
    clk_sys_i = 1'b0; rst_i = 1'b1; psel_i = 1'b0; penable_i = 1'b0;
    pwrite_i = 1'b0; paddr_i = 8'h00; pwdata_i = 32'h0000_0000;
    sys_reset_req_i = 1'b0; ep_events_i = 40'h00_0000_0000;
  end

  udc_usb_host_model udc_usb_host_model_i (
    .clk_sys_i(clk_sys_i), .bus_end_of_reset_o(bus_end_of_reset),
    .bus_suspend_o(susp), .bus_non_idle_o(nidle),
    .dplus_o(dp), .dminus_o(dm));

  udc_core_ctrl udc_core_ctrl_i (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .sys_reset_req_i(sys_reset_req_i),
    .bus_end_of_reset_i(bus_end_of_reset), .bus_suspend_i(susp),
    .bus_non_idle_i(nidle), .dplus_i(dp), .dminus_i(dm),
    .ep_events_i(ep_events_i), .line_buffers_en_o(lbuf),
    .pads_idle_o(idle), .pullup_en_o(pull), .ctrl_clk_en_o(clken),
    .ctrl_soft_reset_o(srst), .memory_direct_access_enable_o(maen),
    .memory_direct_access_address_o(maddr),
    .speed_config_bits_o(spd), .ep_region_o(region),
    .general_irq_o(gen_irq), .endpoint_irq_o(ep_irq), .cpu_wake_o(wake));

  // One APB transfer; the request stands until pready is sampled high or 50 cycles pass.
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys_i);
    psel_i <= 1'b1; penable_i <= 1'b0; pwrite_i <= w;
    paddr_i <= a; pwdata_i <= d;
    @(posedge clk_sys_i);
    penable_i <= 1'b1;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (pready_o !== 1'b1 && n < 50);
    rdata = prdata_o;
    last_err = pslverr_o;
    if (n >= 50) mismatches++;
    psel_i <= 1'b0; penable_i <= 1'b0;
    // Let the write settle before callers look at outputs.
    @(negedge clk_sys_i);
  endtask

  // Compare one value and count it.
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Read a register and compare the bits under a mask.
  task automatic rd(input logic [7:0] a, input logic [31:0] m,
                    input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk("register", e & m, rdata & m);
  endtask

  // Select an endpoint and write its configuration.
  task automatic epcfg(input logic [31:0] ep, input logic [31:0] c);
    apb(1'b1, ADDR_EP_SELECT, ep);
    apb(1'b1, ADDR_EP_CONFIG, c);
  endtask

  // Pad, enable and clock outputs as one vector.
  function automatic logic [31:0] pads();
    return {27'h0, lbuf, idle, pull, clken, srst};
  endfunction

  // Reset state, reset-time writes and an unmapped address.
  task automatic t_reset;
    chk("pads", 32'h0000_0009, pads());
    rd(ADDR_GENERAL_CONTROL, 32'h0000_00FF, 32'h0000_0020);
    rd(ADDR_DEVICE_CONTROL, 32'h0000_0001, 32'h0000_0001);
    apb(1'b1, ADDR_MEM_ADDRESS, 32'h0001_07FF);
    chk("maddr", 32'h0000_0FFF, {20'h0, maen, maddr});
    apb(1'b1, ADDR_GENERAL_CONTROL, 32'h0000_0023);
    chk("speed", 32'h0000_0003, {30'h0, spd});
    apb(1'b0, 8'hFC, 32'h0000_0000);
    chk("slverr", 32'h0000_0001, {31'h0, last_err});
    $display("test reset done");
  endtask

  // Enable, attach, detach and attach again.
  task automatic t_enable;
    apb(1'b1, ADDR_GENERAL_CONTROL, 32'h0000_0081);
    chk("enabled", 32'h0000_001A, pads());
    apb(1'b1, ADDR_DEVICE_CONTROL, 32'h0000_0000);
    chk("attached", 32'h0000_0016, pads());
    apb(1'b1, ADDR_DEVICE_CONTROL, 32'h0000_0001);
    chk("detached", 32'h0000_001A, pads());
    apb(1'b1, ADDR_DEVICE_CONTROL, 32'h0000_0000);
    $display("test enable done");
  endtask

  // Suspend then non-idle bus events with the suspend interrupt on.
  task automatic t_suspend;
    apb(1'b1, ADDR_DEVICE_INT_EN, 32'h0000_0001);
    udc_usb_host_model_i.pulse(0);
    repeat (2) @(posedge clk_sys_i);
    chk("susp irq", 32'h0000_0007, {29'h0, idle, gen_irq, wake});
    rd(ADDR_DEVICE_INT, 32'h0000_0001, 32'h0000_0001);
    udc_usb_host_model_i.pulse(1);
    repeat (2) @(posedge clk_sys_i);
    chk("pads woke", 32'h0000_0000, {31'h0, idle});
    rd(ADDR_DEVICE_INT, 32'h0000_0011, 32'h0000_0010);
    apb(1'b1, ADDR_DEVICE_INT, 32'h0000_0000);
    chk("irq clear", 32'h0000_0000, {31'h0, gen_irq});
    $display("test suspend done");
  endtask

  // Endpoint event on an enabled source raises only the endpoint vector.
  task automatic t_ep_irq;
    apb(1'b1, ADDR_EP_SELECT, 32'h0000_0002);
    apb(1'b1, ADDR_EP_INT_EN, 32'h0000_0008);
    @(posedge clk_sys_i);
    ep_events_i <= 40'h00_0004_0000;
    @(posedge clk_sys_i);
    ep_events_i <= 40'h00_0008_0000;
    repeat (2) @(posedge clk_sys_i);
    chk("ep irq", 32'h0000_0002, {30'h0, ep_irq, gen_irq});
    ep_events_i <= 40'h00_0000_0000;
    apb(1'b1, ADDR_EP_INT, 32'h0000_0000);
    chk("ep clr", 32'h0000_0000, {31'h0, ep_irq});
    $display("test endpoint irq done");
  endtask

  // Reserve endpoints in order, free and re-reserve the middle one.
  task automatic t_memory;
    epcfg(0, 32'h0000_0033);
    epcfg(1, 32'h0000_0023);
    epcfg(2, 32'h0000_0013);
    epcfg(3, 32'h0000_0013);
    chk("ep1 base", 32'h0000_0040, {23'h0, region[17:9]});
    chk("ep3 base", 32'h0000_0070, {23'h0, region[35:27]});
    epcfg(1, 32'h0000_0021);
    chk("ep2 down", 32'h0000_0040, {23'h0, region[26:18]});
    chk("ep3 stays", 32'h0000_0070, {23'h0, region[35:27]});
    chk("ep0 base", 32'h0000_0000, {23'h0, region[8:0]});
    epcfg(1, 32'h0000_0023);
    chk("ep2 up", 32'h0000_0060, {23'h0, region[26:18]});
    epcfg(2, 32'h0000_0053);
    rd(ADDR_EP_CONFIG, 32'h0000_0100, 32'h0000_0100);
    epcfg(2, 32'h0000_0052);
    rd(ADDR_EP_CONFIG, 32'h0000_007E, 32'h0000_0052);
    $display("test memory done");
  endtask

  // Frozen clock: synchronous events ignored, line activity still wakes.
  task automatic t_freeze;
    apb(1'b1, ADDR_GENERAL_CONTROL, 32'h0000_00A1);
    chk("frozen", 32'h0000_0000, {31'h0, clken});
    rd(ADDR_GENERAL_CONTROL, 32'h0000_00FF, 32'h0000_00A1);
    udc_usb_host_model_i.pulse(0);
    rd(ADDR_DEVICE_INT, 32'h0000_0001, 32'h0000_0000);
    udc_usb_host_model_i.resume();
    repeat (6) @(posedge clk_sys_i);
    rd(ADDR_DEVICE_INT, 32'h0000_0010, 32'h0000_0010);
    apb(1'b1, ADDR_GENERAL_CONTROL, 32'h0000_0081);
    $display("test freeze done");
  endtask

  // Bus end of reset keeps enable; a system reset disables.
  task automatic t_resets;
    apb(1'b1, ADDR_EP_CONFIG, 32'h0000_0053);
    udc_usb_host_model_i.pulse(2);
    repeat (2) @(posedge clk_sys_i);
    rd(ADDR_EP_CONFIG, 32'h0000_007F, 32'h0000_0052);
    rd(ADDR_GENERAL_CONTROL, 32'h0000_0080, 32'h0000_0080);
    rd(ADDR_DEVICE_INT, 32'h0000_0008, 32'h0000_0008);
    chk("eor bufs", 32'h0000_0001, {31'h0, lbuf});
    @(posedge clk_sys_i);
    sys_reset_req_i <= 1'b1;
    @(posedge clk_sys_i);
    sys_reset_req_i <= 1'b0;
    @(posedge clk_sys_i);
    chk("sys rst", 32'h0000_0009, pads());
    rd(ADDR_GENERAL_CONTROL, 32'h0000_00A0, 32'h0000_0020);
    $display("test resets done");
  endtask

  // Counts, verdict and end of run.
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Watchdog sized well beyond the fewer than two hundred cycles the tests need.
  initial begin
    #200000;
    mismatches++;
    summarize();
  end

  // Main sequence.
  initial begin
    mismatches = 0;
    checks_done = 0;
    repeat (3) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    @(posedge clk_sys_i);
    t_reset();
    t_enable();
    t_suspend();
    t_ep_irq();
    t_memory();
    t_freeze();
    t_resets();
    summarize();
  end
endmodule
